// file: verilog/pmbus_fault_status_bytes.sv
// Paged and global fault status bytes read by command code
`timescale 1ns/1ps
module pmbus_fault_status_bytes
  import fault_status_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Paged fault events, one pulse or level per rail
  input wire logic [RAILS-1:0] out_overvolt_flag,
  input wire logic [RAILS-1:0] out_undervolt_flag,
  input wire logic [RAILS-1:0] out_volt_ceiling_warn,
  input wire logic [RAILS-1:0] out_overcurrent_flag,
  input wire logic [RAILS-1:0] out_undercurrent_flag,
  input wire logic [RAILS-1:0] current_share_flag,
  input wire logic [RAILS-1:0] in_overvolt_flag,
  input wire logic [RAILS-1:0] in_overvolt_warning,
  input wire logic [RAILS-1:0] in_undervolt_warning,
  input wire logic [RAILS-1:0] in_undervolt_flag,
  input wire logic [RAILS-1:0] input_too_low_disabled,
  input wire logic [RAILS-1:0] in_overcurrent_flag,
  input wire logic [RAILS-1:0] in_overcurrent_warning,
  input wire logic [RAILS-1:0] overheat_flag,
  input wire logic [RAILS-1:0] overheat_warning,
  input wire logic [RAILS-1:0] undercool_flag,
  // Global communications, memory and logic events
  input wire logic bad_command_flag,
  input wire logic bad_payload_flag,
  input wire logic packet_check_fail_flag,
  input wire logic memory_error_flag,
  input wire logic processor_error_flag,
  input wire logic other_comm_error_flag,
  input wire logic other_memlogic_error_flag,
  // Page and command from the bus interface
  input wire logic [PAGE_W-1:0] page,
  input wire logic [7:0] cmd_code,
  input wire logic read_req,
  // Clear strobe: one strobe for all bytes, cmd_code picks the byte; mask of bits to clear
  input wire logic clear_req,
  input wire logic [7:0] clear_mask,
  // Read answer
  output logic [7:0] read_data,
  output logic read_valid,
  output logic read_bad_cmd,
  // Summary flag
  output logic comm_logic_summary
);
  // =========================================================
  // Event vectors
  logic [7:0] vout_ev [RAILS];
  logic [7:0] iout_ev [RAILS];
  logic [7:0] in_ev [RAILS];
  logic [7:0] temp_ev [RAILS];
  logic [7:0] comm_ev;
  logic [7:0] vout_st [RAILS];
  logic [7:0] iout_st [RAILS];
  logic [7:0] in_st [RAILS];
  logic [7:0] temp_st [RAILS];
  logic [7:0] comm_st;
  logic [7:0] mux_byte;
  logic mux_hit;
  logic bad_cmd_ev;
  logic [3:0] clr_sel;
  logic clr_comm;

  always_comb begin
    for (int r = 0; r < RAILS; r++) begin
      vout_ev[r] = 8'h00;
      vout_ev[r][VOUT_OV_BIT] = out_overvolt_flag[r];
      vout_ev[r][VOUT_UV_BIT] = out_undervolt_flag[r];
      vout_ev[r][VOUT_MAX_BIT] = out_volt_ceiling_warn[r];
      iout_ev[r] = 8'h00;
      iout_ev[r][IOUT_OC_BIT] = out_overcurrent_flag[r];
      iout_ev[r][IOUT_UC_BIT] = out_undercurrent_flag[r];
      iout_ev[r][IOUT_SHARE_BIT] = current_share_flag[r];
      in_ev[r] = 8'h00;
      in_ev[r][IN_OVF_BIT] = in_overvolt_flag[r];
      in_ev[r][IN_OVW_BIT] = in_overvolt_warning[r];
      in_ev[r][IN_UVW_BIT] = in_undervolt_warning[r];
      in_ev[r][IN_UVF_BIT] = in_undervolt_flag[r];
      in_ev[r][IN_LOW_BIT] = input_too_low_disabled[r];
      in_ev[r][IN_OCF_BIT] = in_overcurrent_flag[r];
      in_ev[r][IN_OCW_BIT] = in_overcurrent_warning[r];
      temp_ev[r] = 8'h00;
      temp_ev[r][TEMP_OTF_BIT] = overheat_flag[r];
      temp_ev[r][TEMP_OTW_BIT] = overheat_warning[r];
      temp_ev[r][TEMP_UTF_BIT] = undercool_flag[r];
    end
  end

  // An unknown command read is itself logged as a bad command
  assign bad_cmd_ev = read_req & ~mux_hit;

  always_comb begin
    comm_ev = 8'h00;
    comm_ev[COMM_CMD_BIT] = bad_command_flag | bad_cmd_ev;
    comm_ev[COMM_DATA_BIT] = bad_payload_flag;
    comm_ev[COMM_PEC_BIT] = packet_check_fail_flag;
    comm_ev[COMM_MEM_BIT] = memory_error_flag;
    comm_ev[COMM_PROC_BIT] = processor_error_flag;
    comm_ev[COMM_OTHER_BIT] = other_comm_error_flag;
    comm_ev[COMM_LOGIC_BIT] = other_memlogic_error_flag;
  end

  // =========================================================
  // Clear decode: clear_req with cmd_code picks the byte, on current page for paged bytes
  // A clear naming an unknown code does nothing; only a read logs it
  always_comb begin
    clr_sel = 4'b0000;
    clr_comm = 1'b0;
    if (clear_req) begin
      case (cmd_code)
        CMD_OUTPUT_VOLTAGE_STATUS: clr_sel = SEL_VOUT;
        CMD_OUTPUT_CURRENT_STATUS: clr_sel = SEL_IOUT;
        CMD_INPUT_SUPPLY_STATUS: clr_sel = SEL_INPUT;
        CMD_THERMAL_STATUS: clr_sel = SEL_TEMP;
        CMD_COMM_LOGIC_MEMORY_STATUS: clr_comm = 1'b1;
        default: clr_sel = 4'b0000;
      endcase
    end
  end

  // =========================================================
  // Storage: per-rail copies and one global byte
  for (genvar g = 0; g < RAILS; g++) begin : g_rail
    logic here;
    assign here = (page == PAGE_W'(g));
    sticky_status_byte u_vout (
      .clk(clk), .rst_n(rst_n), .set_ev(vout_ev[g]),
      .clr_bits((here && clr_sel[0]) ? clear_mask : 8'h00),
      .supported(VOUT_MASK), .value(vout_st[g]));
    sticky_status_byte u_iout (
      .clk(clk), .rst_n(rst_n), .set_ev(iout_ev[g]),
      .clr_bits((here && clr_sel[1]) ? clear_mask : 8'h00),
      .supported(IOUT_MASK), .value(iout_st[g]));
    sticky_status_byte u_input (
      .clk(clk), .rst_n(rst_n), .set_ev(in_ev[g]),
      .clr_bits((here && clr_sel[2]) ? clear_mask : 8'h00),
      .supported(INPUT_MASK), .value(in_st[g]));
    sticky_status_byte u_temp (
      .clk(clk), .rst_n(rst_n), .set_ev(temp_ev[g]),
      .clr_bits((here && clr_sel[3]) ? clear_mask : 8'h00),
      .supported(TEMP_MASK), .value(temp_st[g]));
  end

  sticky_status_byte u_comm (
    .clk(clk),
    .rst_n(rst_n),
    .set_ev(comm_ev),
    .clr_bits(clr_comm ? clear_mask : 8'h00),
    .supported(COMM_MASK),
    .value(comm_st)
  );

  // =========================================================
  // Read path: one byte per read, registered
  // read_data keeps the last byte between reads; only the pulses mark news
  status_read_mux u_mux (
    .cmd_code(cmd_code),
    .vout_b(vout_st[page]),
    .iout_b(iout_st[page]),
    .input_b(in_st[page]),
    .temp_b(temp_st[page]),
    .comm_b(comm_st),
    .byte_out(mux_byte),
    .hit(mux_hit)
  );

  logic [7:0] read_data_r, read_data_nxt;
  logic read_valid_r, read_valid_nxt;
  logic read_bad_r, read_bad_nxt;
  logic summary_r, summary_nxt;

  always_comb begin
    read_data_nxt = read_data_r;
    read_valid_nxt = 1'b0;
    read_bad_nxt = 1'b0;
    if (read_req) begin
      read_data_nxt = mux_hit ? mux_byte : 8'h00;
      read_valid_nxt = mux_hit;
      read_bad_nxt = ~mux_hit;
    end
    summary_nxt = |comm_st;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      read_data_r <= STATUS_RESET;
      read_valid_r <= 1'b0;
      read_bad_r <= 1'b0;
      summary_r <= 1'b0;
    end else begin
      read_data_r <= read_data_nxt;
      read_valid_r <= read_valid_nxt;
      read_bad_r <= read_bad_nxt;
      summary_r <= summary_nxt;
    end
  end

  assign read_data = read_data_r;
  assign read_valid = read_valid_r;
  assign read_bad_cmd = read_bad_r;
  assign comm_logic_summary = summary_r;

  // =========================================================
  // Assertions
  // Single-bit spot checks of the event wiring, one rail each
  AST_OV_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    out_overvolt_flag[0] |=> vout_st[0][VOUT_OV_BIT])
    else $error("overvoltage not latched");
  AST_UV_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    out_undervolt_flag[1] |=> vout_st[1][VOUT_UV_BIT])
    else $error("undervoltage not latched");
  AST_OC_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    out_overcurrent_flag[0] |=> iout_st[0][IOUT_OC_BIT])
    else $error("overcurrent not latched");
  AST_INLOW_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    input_too_low_disabled[0] |=> in_st[0][IN_LOW_BIT])
    else $error("input low not latched");
  AST_OT_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    overheat_flag[1] |=> temp_st[1][TEMP_OTF_BIT])
    else $error("overheat not latched");
  // Whole-byte latching: every raised event bit is held on the next edge
  AST_VOUT_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (vout_ev[1] != 8'h00) |=> ((vout_st[1] & $past(vout_ev[1])) == $past(vout_ev[1])))
    else $error("voltage byte bit not latched");
  AST_IOUT_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (iout_ev[0] != 8'h00) |=> ((iout_st[0] & $past(iout_ev[0])) == $past(iout_ev[0])))
    else $error("current byte bit not latched");
  AST_INPUT_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (in_ev[0] != 8'h00) |=> ((in_st[0] & $past(in_ev[0])) == $past(in_ev[0])))
    else $error("input byte bit not latched");
  AST_TEMP_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (temp_ev[0] != 8'h00) |=> ((temp_st[0] & $past(temp_ev[0])) == $past(temp_ev[0])))
    else $error("thermal byte bit not latched");
  AST_COMM_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (comm_ev != 8'h00) |=> ((comm_st & $past(comm_ev)) == $past(comm_ev)))
    else $error("comm byte bit not latched");
  // Set wins over a clear of the same byte in the same cycle
  AST_PEC_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    (packet_check_fail_flag && clr_comm) |=> comm_st[COMM_PEC_BIT])
    else $error("set lost against clear");
  AST_CLEAR_PAGED: assert property (@(posedge clk) disable iff (!rst_n)
    (clr_sel[0] && page == 1'b0)
    |=> ((vout_st[0] & $past(clear_mask & ~vout_ev[0])) == 8'h00))
    else $error("clear missed the selected page");
  AST_BADCMD: assert property (@(posedge clk) disable iff (!rst_n)
    (read_req && !mux_hit) |=> (read_bad_cmd && comm_st[COMM_CMD_BIT]))
    else $error("bad command not logged");
  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    (|comm_st) |=> comm_logic_summary)
    else $error("summary flag missing");
  AST_SUMMARY_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (comm_st == 8'h00) |=> !comm_logic_summary)
    else $error("summary flag without cause");
  // Each read gets exactly one answer, a byte or a refusal
  AST_ONE_BYTE: assert property (@(posedge clk) disable iff (!rst_n)
    read_req |=> (read_valid != read_bad_cmd))
    else $error("read not answered once");
  AST_ANSWER_ASKED: assert property (@(posedge clk) disable iff (!rst_n)
    (read_valid || read_bad_cmd) |-> $past(read_req))
    else $error("answer without request");
  AST_UNSUP_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    ((vout_st[0] & ~VOUT_MASK) == 8'h00) && ((iout_st[1] & ~IOUT_MASK) == 8'h00)
    && ((in_st[0] & ~INPUT_MASK) == 8'h00) && ((temp_st[1] & ~TEMP_MASK) == 8'h00)
    && ((comm_st & ~COMM_MASK) == 8'h00))
    else $error("unsupported bit set");
  // A raise on rail 0 alone must leave the rail 1 copy untouched
  AST_PAGE_SEPARATE: assert property (@(posedge clk) disable iff (!rst_n)
    (out_overvolt_flag == 2'b01 && !vout_st[1][VOUT_OV_BIT] && !clear_req)
    |=> !vout_st[1][VOUT_OV_BIT])
    else $error("rail copies not separate");
  // Main scenarios
  COV_READ: cover property (@(posedge clk) disable iff (!rst_n) read_valid);
  COV_BAD: cover property (@(posedge clk) disable iff (!rst_n) read_bad_cmd);
  COV_SUM: cover property (@(posedge clk) disable iff (!rst_n) comm_logic_summary);
  COV_CLR: cover property (@(posedge clk) disable iff (!rst_n) clr_sel != 4'b0000);
  COV_SET_CLEAR: cover property (@(posedge clk) disable iff (!rst_n)
    packet_check_fail_flag && clr_comm);
endmodule // pmbus_fault_status_bytes

// file: verilog/fault_status_pkg.sv
// Package of command codes, bit positions and sizes for the fault status bytes
package fault_status_pkg;
  localparam int RAILS = 2;
  localparam int PAGE_W = 1;
  localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS = 8'h7a;
  localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
  localparam logic [7:0] CMD_INPUT_SUPPLY_STATUS = 8'h7c;
  localparam logic [7:0] CMD_THERMAL_STATUS = 8'h7d;
  localparam logic [7:0] CMD_COMM_LOGIC_MEMORY_STATUS = 8'h7e;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int STATUS_BYTE_COUNT = 1;
  localparam int SUMMARY_CML_BIT = 1;
  // Event vector positions (source bit = register bit)
  localparam int VOUT_OV_BIT = 7;
  localparam int VOUT_UV_BIT = 4;
  localparam int VOUT_MAX_BIT = 3;
  localparam int IOUT_OC_BIT = 7;
  localparam int IOUT_UC_BIT = 4;
  localparam int IOUT_SHARE_BIT = 3;
  localparam int IN_OVF_BIT = 7;
  localparam int IN_OVW_BIT = 6;
  localparam int IN_UVW_BIT = 5;
  localparam int IN_UVF_BIT = 4;
  localparam int IN_LOW_BIT = 3;
  localparam int IN_OCF_BIT = 2;
  localparam int IN_OCW_BIT = 1;
  localparam int TEMP_OTF_BIT = 7;
  localparam int TEMP_OTW_BIT = 6;
  localparam int TEMP_UTF_BIT = 4;
  localparam int COMM_CMD_BIT = 7;
  localparam int COMM_DATA_BIT = 6;
  localparam int COMM_PEC_BIT = 5;
  localparam int COMM_MEM_BIT = 4;
  localparam int COMM_PROC_BIT = 3;
  localparam int COMM_OTHER_BIT = 1;
  localparam int COMM_LOGIC_BIT = 0;
  // Supported-bit masks; unsupported positions stay zero
  localparam logic [7:0] VOUT_MASK = 8'h98;
  localparam logic [7:0] IOUT_MASK = 8'h98;
  localparam logic [7:0] INPUT_MASK = 8'hfe;
  localparam logic [7:0] TEMP_MASK = 8'hd0;
  localparam logic [7:0] COMM_MASK = 8'hfb;
  typedef enum logic [3:0] {
    SEL_VOUT = 4'b0001,
    SEL_IOUT = 4'b0010,
    SEL_INPUT = 4'b0100,
    SEL_TEMP = 4'b1000
  } paged_sel_t;
endpackage

// file: verilog/sticky_status_byte.sv
// One sticky status byte with masked set and clear
`timescale 1ns/1ps
module sticky_status_byte (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events and clear
  input wire logic [7:0] set_ev,
  input wire logic [7:0] clr_bits,
  input wire logic [7:0] supported,
  // State
  output logic [7:0] value
);
  import fault_status_pkg::*;
  logic [7:0] value_r;
  logic [7:0] value_nxt;
  // Set wins over a clear landing in the same cycle
  always_comb begin
    value_nxt = ((value_r & ~clr_bits) | set_ev) & supported;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= STATUS_RESET;
    end else begin
      value_r <= value_nxt;
    end
  end
  assign value = value_r;
endmodule // sticky_status_byte

// file: verilog/status_read_mux.sv
// Selects the byte answered for a status read command
`timescale 1ns/1ps
module status_read_mux (
  // Command
  input wire logic [7:0] cmd_code,
  // Bytes of the selected page and the global comm byte
  input wire logic [7:0] vout_b,
  input wire logic [7:0] iout_b,
  input wire logic [7:0] input_b,
  input wire logic [7:0] temp_b,
  input wire logic [7:0] comm_b,
  // Result
  output logic [7:0] byte_out,
  output logic hit
);
  import fault_status_pkg::*;
  always_comb begin
    byte_out = 8'h00;
    hit = 1'b1;
    case (cmd_code)
      CMD_OUTPUT_VOLTAGE_STATUS: byte_out = vout_b;
      CMD_OUTPUT_CURRENT_STATUS: byte_out = iout_b;
      CMD_INPUT_SUPPLY_STATUS: byte_out = input_b;
      CMD_THERMAL_STATUS: byte_out = temp_b;
      CMD_COMM_LOGIC_MEMORY_STATUS: byte_out = comm_b;
      default: hit = 1'b0;
    endcase
  end
endmodule // status_read_mux

// file: tb/status_host_model.sv
// Host side model that issues status reads and clears one request at a time
`timescale 1ns/1ps
module status_host_model
  import fault_status_pkg::*;
(
  // Clock
  input wire logic clk,
  // Requests to the device
  output logic read_req,
  output logic clear_req,
  output logic [7:0] cmd_code,
  output logic [PAGE_W-1:0] page,
  output logic [7:0] clear_mask,
  // Answer from the device
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic read_bad_cmd
);
  // ======
  // Idle bus
  initial begin
    read_req = 1'b0;
    clear_req = 1'b0;
    cmd_code = 8'h00;
    page = '0;
    clear_mask = 8'h00;
  end

  // Released lines must not look like the last request
  task automatic release_bus;
    cmd_code = ~cmd_code;
    page = ~page;
    clear_mask = ~clear_mask;
  endtask

  // ======
  // Transfers
  // One data byte is taken per read, answer awaited a bounded time
  task automatic rd(input logic [7:0] c, input logic [PAGE_W-1:0] p, output logic [7:0] d,
                    output logic vld, output logic bad);
    int n;
    @(negedge clk);
    cmd_code = c;
    page = p;
    read_req = 1'b1;
    @(negedge clk);
    read_req = 1'b0;
    release_bus();
    n = 0;
    while (read_valid !== 1'b1 && read_bad_cmd !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    d = read_data;
    vld = read_valid;
    bad = read_bad_cmd;
  endtask

  task automatic clr(input logic [7:0] c, input logic [PAGE_W-1:0] p, input logic [7:0] m);
    @(negedge clk);
    cmd_code = c;
    page = p;
    clear_mask = m;
    clear_req = 1'b1;
    @(negedge clk);
    clear_req = 1'b0;
    release_bus();
  endtask
endmodule // status_host_model

// file: tb/pmbus_fault_status_bytes_tb.sv
// Self-checking bench for the fault status bytes against a bit-level model
`timescale 1ns/1ps
module pmbus_fault_status_bytes_tb;
  import fault_status_pkg::*;
  // ======
  // Signals and model state
  logic clk;
  logic rst_n;
  logic [RAILS-1:0] pev [16];
  logic [6:0] gev;
  logic rd_req, clr_req, vld, bad, summ;
  logic [7:0] cmd, mask, rdata;
  logic [PAGE_W-1:0] pg;
  logic [7:0] mdl [4][RAILS];
  logic [7:0] comm;
  int seed = 70;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  // Byte and bit set by each paged event, in port order
  int ev_reg [16] = '{0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3};
  int ev_bit [16] = '{7, 4, 3, 7, 4, 3, 7, 6, 5, 4, 3, 2, 1, 7, 6, 4};
  int comm_bit [7] = '{7, 6, 5, 4, 3, 1, 0};

  pmbus_fault_status_bytes u_dut (
    .clk(clk), .rst_n(rst_n),
    .out_overvolt_flag(pev[0]), .out_undervolt_flag(pev[1]), .out_volt_ceiling_warn(pev[2]),
    .out_overcurrent_flag(pev[3]), .out_undercurrent_flag(pev[4]),
    .current_share_flag(pev[5]), .in_overvolt_flag(pev[6]), .in_overvolt_warning(pev[7]),
    .in_undervolt_warning(pev[8]), .in_undervolt_flag(pev[9]),
    .input_too_low_disabled(pev[10]), .in_overcurrent_flag(pev[11]),
    .in_overcurrent_warning(pev[12]), .overheat_flag(pev[13]), .overheat_warning(pev[14]),
    .undercool_flag(pev[15]), .bad_command_flag(gev[0]), .bad_payload_flag(gev[1]),
    .packet_check_fail_flag(gev[2]), .memory_error_flag(gev[3]),
    .processor_error_flag(gev[4]), .other_comm_error_flag(gev[5]),
    .other_memlogic_error_flag(gev[6]), .page(pg), .cmd_code(cmd), .read_req(rd_req),
    .clear_req(clr_req), .clear_mask(mask), .read_data(rdata), .read_valid(vld),
    .read_bad_cmd(bad), .comm_logic_summary(summ)
  );

  status_host_model u_host (
    .clk(clk), .read_req(rd_req), .clear_req(clr_req), .cmd_code(cmd), .page(pg),
    .clear_mask(mask), .read_data(rdata), .read_valid(vld), .read_bad_cmd(bad)
  );

  // ======
  // Checking helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic clear_model;
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < RAILS; j++)
        mdl[i][j] = 8'h00;
    comm = 8'h00;
  endtask

  task automatic apply_model;
    for (int i = 0; i < 16; i++) begin
      for (int r = 0; r < RAILS; r++) begin
        if (pev[i][r])
          mdl[ev_reg[i]][r] |= 8'(1 << ev_bit[i]);
      end
    end
    for (int i = 0; i < 7; i++) begin
      if (gev[i])
        comm |= 8'(1 << comm_bit[i]);
    end
  endtask

  // Reads every byte of every page and the summary flag
  task automatic verify_all;
    logic [7:0] d;
    logic v, b;
    for (int p = 0; p < RAILS; p++) begin
      for (int k = 0; k < 5; k++) begin
        u_host.rd(8'(CMD_OUTPUT_VOLTAGE_STATUS + k), PAGE_W'(p), d, v, b);
        chk("valid", {7'h00, v}, 8'h01);
        chk("refused", {7'h00, b}, 8'h00);
        chk("status", d, (k == 4) ? comm : mdl[k % 4][p]);
        @(negedge clk);
        chk("valid once", {7'h00, vld}, 8'h00);
        chk("data held", rdata, d);
      end
    end
    chk("summary", {7'h00, summ}, {7'h00, comm != 8'h00});
  endtask

  // ======
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Whole run needs a few thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    logic [7:0] d, m;
    logic v, b;
    int k, p;
    rst_n = 1'b0;
    gev = '0;
    foreach (pev[i]) pev[i] = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    clear_model();
    verify_all();
    for (int n = 0; n < 40; n++) begin
      @(negedge clk);
      foreach (pev[i]) pev[i] = RAILS'($random(seed) & $random(seed) & $random(seed));
      gev = 7'($random(seed) & $random(seed) & $random(seed));
      apply_model();
      @(negedge clk);
      foreach (pev[i]) pev[i] = '0;
      gev = '0;
      repeat (2) @(negedge clk);
      verify_all();
      u_host.rd((n % 2) ? 8'h7f : 8'h00, PAGE_W'(n), d, v, b);
      chk("unknown flag", {7'h00, b}, 8'h01);
      chk("unknown valid", {7'h00, v}, 8'h00);
      chk("unknown data", d, 8'h00);
      comm |= 8'h80;
      k = (n % 4 == 0) ? 4 : $unsigned($random(seed)) % 5;
      p = $unsigned($random(seed)) % RAILS;
      m = 8'($random(seed));
      if (k == 4)
        comm &= ~m;
      else
        mdl[k][p] &= ~m;
      // Fresh events in the clear's own cycle must survive it
      fork
        u_host.clr(8'(CMD_OUTPUT_VOLTAGE_STATUS + k), PAGE_W'(p), m);
        begin
          @(negedge clk);
          foreach (pev[i]) pev[i] = RAILS'($random(seed));
          gev = 7'($random(seed));
          apply_model();
          @(negedge clk);
          foreach (pev[i]) pev[i] = '0;
          gev = '0;
        end
      join
      repeat (2) @(negedge clk);
      verify_all();
    end
    // Reset in mid-run wipes every byte
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    clear_model();
    verify_all();
    wrap_up();
  end
endmodule // pmbus_fault_status_bytes_tb
